// File: src/opm_pkg.sv
// Package for the operating-mode control block: modes, sizes and carriers
package opm_pkg;

    // ****************************************************************
    // Modes and sizes
    // ****************************************************************
    typedef enum logic [2:0] {
        OPM_REAL,
        OPM_PROT,
        OPM_VREAL,
        OPM_LONG64,
        OPM_COMPAT,
        OPM_MGMT
    } opm_mode_e;

    typedef enum logic [1:0] {
        OPM_SZ16,
        OPM_SZ32,
        OPM_SZ64
    } opm_size_e;

    localparam logic [1:0] OPM_PL_KERNEL  = 2'h0;
    localparam logic [1:0] OPM_PL_USER    = 2'h3;
    localparam int         OPM_SEG_SHIFT  = 4;
    localparam logic [1:0] OPM_AS_1M      = 2'h0;
    localparam logic [1:0] OPM_AS_4G      = 2'h1;
    localparam logic [1:0] OPM_AS_FULL    = 2'h2;

    // ****************************************************************
    // Wishbone register map (word offsets as byte addresses)
    // ****************************************************************
    localparam logic [7:0] OPM_REG_CTRL   = 8'h00;
    localparam logic [7:0] OPM_REG_FLAGS  = 8'h04;
    localparam logic [7:0] OPM_REG_STATUS = 8'h08;
    localparam logic [7:0] OPM_REG_XLAT   = 8'h0c;
    localparam int OPM_CTRL_PE  = 0;
    localparam int OPM_CTRL_PG  = 1;
    localparam int OPM_CTRL_LME = 2;
    localparam int OPM_CTRL_CSL = 3;
    localparam int OPM_CTRL_CSD = 4;
    localparam int OPM_FLAGS_VM = 0;
    localparam logic [31:0] OPM_CTRL_RST  = 32'h0000_0000;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } opm_wb_req_s;

    typedef struct packed {
        logic        mgmt_int;
        logic        mgmt_exit;
        logic        task_switch;
        logic        interrupt_return_instruction;
        logic        flag_pop;
        logic        vm_value;
        logic [1:0]  cur_pl;
    } opm_evt_s;

    typedef struct packed {
        opm_mode_e   mode;
        opm_size_e   addr_size;
        opm_size_e   oper_size;
        logic [1:0]  pl_min;
        logic [1:0]  pl_max;
        logic        paging_avail;
        logic        paging_req;
        logic        reg_ext;
        logic        wide_ip;
        logic        ip_rel;
        logic        flat_seg;
        logic        long_xlat;
        logic        prefix_toggle;
        logic [1:0]  addr_space;
    } opm_attr_s;

    typedef struct packed {
        logic        pe;
        logic        pg;
        logic        lme;
        logic        lma;
        logic        cs_long;
        logic        cs_def32;
        logic        vm;
        logic        mgmt;
        logic        ack;
        logic [31:0] rdat;
        logic [15:0] seg;
        logic [15:0] off;
        logic [19:0] phys;
        opm_attr_s   attr;
    } opm_state_s;

endpackage : opm_pkg

// File: src/opm_core.sv
// Operating-mode control: mode tracking, size defaults and mode-entry checks
// Function
// - Reset places the core in real mode first.
// - 64-bit submode: default address 64 bits, operand 32 bits.
// - Real mode: 1 Mbyte memory, 16-bit operands, no paging.
// - Real mode runs everything at privilege level zero.
// - Real mode unavailable while long mode is in effect.
// - With long mode enabled, attempts to set virtual-machine flag are ignored.
// - Virtual-machine flag changes only on task switch or privileged return, and is cleared when long mode is enabled.
// - Flag-pop instruction never changes the virtual-machine flag.
// - Setting the virtual-machine flag enters virtual real-address mode.
// - Virtual real mode: level 3, 1 Mbyte, real translation, 16-bit.
// - Submode chosen per code segment from its long attribute.
// - Compatibility submode limits applications to first 4 Gbytes.
// - Compatibility prefixes toggle sizes between 16 and 32 bits.
// - Compatibility uses legacy segmentation with long-mode translation structures.
// - 64-bit submode requires paging and uses flat segmentation.
// - Unpaged protected mode passes addresses through within 4 Gbytes.
// - Protected mode supports privilege levels 0 to 3.
// - Only 64-bit submode exposes upper register bits and extra registers.
// - 64-bit submode extension prefix selects 64-bit operands, added registers.
// - 64-bit submode provides wide instruction pointer and relative addressing.
// - Real translation: selector shifted left four plus offset, 20 bits.
// - Management interrupt enters management mode with separate address space.
`timescale 1ns/1ps

module opm_core
    import opm_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        clk_en_i,
    // Wishbone slave
    input  wire opm_wb_req_s wb_req_i,
    output logic             wb_ack_o,
    output logic [31:0]      wb_dat_o,
    // Core events
    input  wire opm_evt_s    evt_i,
    // Mode outputs
    output opm_mode_e        mode_o,
    output opm_attr_s        attr_o,
    output logic             mgmt_space_o
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic opm_mode_e derive(input logic pe, input logic lma,
                                         input logic csl, input logic vm,
                                         input logic mg);
        if (mg) begin
            return OPM_MGMT;
        end else if (!pe) begin
            return OPM_REAL;
        end else if (lma) begin
            return csl ? OPM_LONG64 : OPM_COMPAT;
        end else if (vm) begin
            return OPM_VREAL;
        end
        return OPM_PROT;
    endfunction

    opm_state_s q, d;
    logic       wr_strb;
    logic [31:0] ctrl_v;
    logic [31:0] nctrl;
    opm_mode_e  nmode;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        d       = q;
        wr_strb = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !q.ack;
        ctrl_v  = {26'h000_0000, q.lma, q.cs_def32, q.cs_long, q.lme, q.pg, q.pe};
        nctrl   = wmerge(ctrl_v, wb_req_i.dat, wb_req_i.sel);
        d.ack   = wb_req_i.cyc && wb_req_i.stb && !q.ack;
        if (wr_strb && wb_req_i.adr == OPM_REG_CTRL) begin
            d.pe       = nctrl[OPM_CTRL_PE];
            d.pg       = nctrl[OPM_CTRL_PG] && nctrl[OPM_CTRL_PE];
            d.cs_long  = nctrl[OPM_CTRL_CSL];
            d.cs_def32 = nctrl[OPM_CTRL_CSD];
            // Long mode only with protection on; once set, a later clear of pe keeps it
            d.lme = nctrl[OPM_CTRL_LME] && (q.pe || q.lme);
            if (q.lma && !(nctrl[OPM_CTRL_PE] && nctrl[OPM_CTRL_PG])) begin
                d.pe = 1'b1;
                d.pg = 1'b1;
            end
        end
        d.lma = d.lme && d.pe && d.pg;
        if (wr_strb && wb_req_i.adr == OPM_REG_XLAT) begin
            d.seg = wb_req_i.dat[31:16];
            d.off = wb_req_i.dat[15:0];
        end
        d.phys = 20'({q.seg, 4'h0}) + 20'(q.off);
        if ((evt_i.task_switch || (evt_i.interrupt_return_instruction && evt_i.cur_pl == OPM_PL_KERNEL))
            && !evt_i.flag_pop && q.pe) begin
            d.vm = evt_i.vm_value && !q.lme;
        end
        if (q.lme) begin
            d.vm = 1'b0;
        end
        if (evt_i.mgmt_int) begin
            d.mgmt = 1'b1;
        end else if (evt_i.mgmt_exit) begin
            d.mgmt = 1'b0;
        end
        nmode  = derive(d.pe, d.lma, d.cs_long, d.vm, d.mgmt);
        d.attr = '0;
        d.attr.mode = nmode;
        case (nmode)
            OPM_REAL: begin
                d.attr.addr_size  = OPM_SZ16;
                d.attr.oper_size  = OPM_SZ16;
                d.attr.pl_min     = OPM_PL_KERNEL;
                d.attr.pl_max     = OPM_PL_KERNEL;
                d.attr.addr_space = OPM_AS_1M;
            end
            OPM_VREAL: begin
                d.attr.addr_size  = OPM_SZ16;
                d.attr.oper_size  = OPM_SZ16;
                d.attr.pl_min     = OPM_PL_USER;
                d.attr.pl_max     = OPM_PL_USER;
                d.attr.addr_space = OPM_AS_1M;
                d.attr.paging_avail = d.pg;
            end
            OPM_PROT: begin
                d.attr.addr_size  = d.cs_def32 ? OPM_SZ32 : OPM_SZ16;
                d.attr.oper_size  = d.cs_def32 ? OPM_SZ32 : OPM_SZ16;
                d.attr.pl_min     = OPM_PL_KERNEL;
                d.attr.pl_max     = OPM_PL_USER;
                d.attr.paging_avail = 1'b1;
                d.attr.addr_space = OPM_AS_4G;
                d.attr.prefix_toggle = 1'b1;
            end
            OPM_COMPAT: begin
                d.attr.addr_size  = d.cs_def32 ? OPM_SZ32 : OPM_SZ16;
                d.attr.oper_size  = d.cs_def32 ? OPM_SZ32 : OPM_SZ16;
                d.attr.pl_min     = OPM_PL_KERNEL;
                d.attr.pl_max     = OPM_PL_USER;
                d.attr.paging_avail = 1'b1;
                d.attr.paging_req = 1'b1;
                d.attr.long_xlat  = 1'b1;
                d.attr.prefix_toggle = 1'b1;
                d.attr.addr_space = OPM_AS_4G;
            end
            OPM_LONG64: begin
                d.attr.addr_size  = OPM_SZ64;
                d.attr.oper_size  = OPM_SZ32;
                d.attr.pl_min     = OPM_PL_KERNEL;
                d.attr.pl_max     = OPM_PL_USER;
                d.attr.paging_avail = 1'b1;
                d.attr.paging_req = 1'b1;
                d.attr.flat_seg   = 1'b1;
                d.attr.long_xlat  = 1'b1;
                d.attr.reg_ext    = 1'b1;
                d.attr.wide_ip    = 1'b1;
                d.attr.ip_rel     = 1'b1;
                d.attr.addr_space = OPM_AS_FULL;
            end
            OPM_MGMT: begin
                d.attr.addr_size  = OPM_SZ16;
                d.attr.oper_size  = OPM_SZ16;
                d.attr.pl_min     = OPM_PL_KERNEL;
                d.attr.pl_max     = OPM_PL_KERNEL;
                d.attr.addr_space = OPM_AS_4G;
                d.attr.prefix_toggle = 1'b1;
            end
            default: begin
                d.attr.mode = OPM_REAL;
            end
        endcase
        d.rdat = 32'h0000_0000;
        case (wb_req_i.adr)
            OPM_REG_CTRL:   d.rdat = ctrl_v;
            OPM_REG_FLAGS:  d.rdat = {31'h0000_0000, q.vm};
            OPM_REG_STATUS: d.rdat = {16'h0000, 2'h0, q.attr.addr_space,
                                      q.attr.pl_max, q.attr.pl_min,
                                      q.attr.oper_size, q.attr.addr_size,
                                      1'b0, q.attr.mode};
            OPM_REG_XLAT:   d.rdat = {12'h000, q.phys};
            default:        d.rdat = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            q      <= '0;
        end else if (clk_en_i) begin
            q <= d;
        end
    end

    assign wb_ack_o     = q.ack;
    assign wb_dat_o     = q.rdat;
    assign mode_o       = q.attr.mode;
    assign attr_o       = q.attr;
    assign mgmt_space_o = q.mgmt;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_reset_real;
        @(posedge ref_clk_i) $rose(resetn_i) |-> mode_o == OPM_REAL;
    endproperty
    a_reset_real: assert property (p_reset_real) else $error("not real after reset");

    property p_sz64;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        mode_o == OPM_LONG64 |-> attr_o.addr_size == OPM_SZ64 && attr_o.oper_size == OPM_SZ32;
    endproperty
    a_sz64: assert property (p_sz64) else $error("64-bit defaults wrong");

    property p_real_attr;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        mode_o == OPM_REAL |-> !attr_o.paging_avail && attr_o.pl_max == OPM_PL_KERNEL;
    endproperty
    a_real_attr: assert property (p_real_attr) else $error("real mode attributes wrong");

    property p_no_real_long;
        @(posedge ref_clk_i) disable iff (!resetn_i) q.lma |-> q.pe && q.pg;
    endproperty
    a_no_real_long: assert property (p_no_real_long) else $error("long without paging");

    property p_vm_long;
        @(posedge ref_clk_i) disable iff (!resetn_i) clk_en_i && q.lme |=> !q.vm;
    endproperty
    a_vm_long: assert property (p_vm_long) else $error("vm set in long mode");

    property p_vm_hold;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        clk_en_i && !evt_i.task_switch && !evt_i.interrupt_return_instruction && !q.lme |=> $stable(q.vm);
    endproperty
    a_vm_hold: assert property (p_vm_hold) else $error("vm changed without cause");

    property p_pop;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        clk_en_i && evt_i.flag_pop && !q.lme |=> $stable(q.vm);
    endproperty
    a_pop: assert property (p_pop) else $error("flag pop changed vm");

    property p_vreal;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        q.vm && q.pe && !q.lma && !q.mgmt |-> mode_o == OPM_VREAL && attr_o.pl_min == OPM_PL_USER;
    endproperty
    a_vreal: assert property (p_vreal) else $error("vm not virtual real");

    property p_xlat;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        clk_en_i |=> q.phys == 20'({$past(q.seg), 4'h0}) + 20'($past(q.off));
    endproperty
    a_xlat: assert property (p_xlat) else $error("real translation wrong");

    property p_ext;
        @(posedge ref_clk_i) disable iff (!resetn_i) attr_o.reg_ext |-> mode_o == OPM_LONG64;
    endproperty
    a_ext: assert property (p_ext) else $error("extensions outside 64-bit");

    // ****************************************************************
    // Sequences and per-mode checks
    // ****************************************************************
    sequence s_ctrl_write;
        clk_en_i && wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !wb_ack_o
            && wb_req_i.adr == OPM_REG_CTRL;
    endsequence

    sequence s_vm_load;
        clk_en_i && evt_i.task_switch && evt_i.vm_value && !evt_i.flag_pop
            && q.pe && !q.lme;
    endsequence

    sequence s_mgmt_req;
        clk_en_i && evt_i.mgmt_int;
    endsequence

    property p_ack_answer;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        clk_en_i && wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("no ack for request");

    property p_ack_pulse;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        clk_en_i && wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

    property p_freeze;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        resetn_i && !clk_en_i |=> $stable(q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled");

    property p_real_size;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        mode_o == OPM_REAL |-> attr_o.addr_space == OPM_AS_1M && attr_o.oper_size == OPM_SZ16;
    endproperty
    a_real_size: assert property (p_real_size) else $error("real mode size wrong");

    property p_prot_pl;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        mode_o == OPM_PROT |-> attr_o.pl_min == OPM_PL_KERNEL && attr_o.pl_max == OPM_PL_USER
            && attr_o.addr_space == OPM_AS_4G;
    endproperty
    a_prot_pl: assert property (p_prot_pl) else $error("prot levels wrong");

    property p_vreal_size;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        mode_o == OPM_VREAL |-> attr_o.addr_space == OPM_AS_1M && attr_o.oper_size == OPM_SZ16
            && attr_o.pl_max == OPM_PL_USER;
    endproperty
    a_vreal_size: assert property (p_vreal_size) else $error("vreal size wrong");

    property p_vm_set;
        @(posedge ref_clk_i) disable iff (!resetn_i) s_vm_load |=> q.vm;
    endproperty
    a_vm_set: assert property (p_vm_set) else $error("vm load lost");

    property p_submode;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        q.lma && !q.mgmt |-> mode_o == (q.cs_long ? OPM_LONG64 : OPM_COMPAT);
    endproperty
    a_submode: assert property (p_submode) else $error("wrong submode");

    property p_compat_space;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        mode_o == OPM_COMPAT |-> attr_o.addr_space == OPM_AS_4G && !attr_o.reg_ext;
    endproperty
    a_compat_space: assert property (p_compat_space) else $error("compat space wrong");

    property p_compat_tgl;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        mode_o == OPM_COMPAT |-> attr_o.prefix_toggle && attr_o.oper_size != OPM_SZ64;
    endproperty
    a_compat_tgl: assert property (p_compat_tgl) else $error("compat sizes wrong");

    property p_compat_xlat;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        mode_o == OPM_COMPAT |-> attr_o.long_xlat && !attr_o.flat_seg;
    endproperty
    a_compat_xlat: assert property (p_compat_xlat) else $error("compat xlat wrong");

    property p_long_page;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        mode_o == OPM_LONG64 |-> attr_o.paging_req && attr_o.flat_seg && q.pg;
    endproperty
    a_long_page: assert property (p_long_page) else $error("64-bit without paging");

    property p_long_ip;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        mode_o == OPM_LONG64 |-> attr_o.wide_ip && attr_o.ip_rel;
    endproperty
    a_long_ip: assert property (p_long_ip) else $error("64-bit pointer missing");

    property p_mgmt;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        s_mgmt_req |=> mgmt_space_o && mode_o == OPM_MGMT;
    endproperty
    a_mgmt: assert property (p_mgmt) else $error("management entry missed");

    property p_lme_order;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        s_ctrl_write ##0 (!q.pe && !q.lme) |=> !q.lme;
    endproperty
    a_lme_order: assert property (p_lme_order) else $error("long before protection");

    property p_lme_keep;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        s_ctrl_write ##0 q.lma |=> q.pe && q.pg;
    endproperty
    a_lme_keep: assert property (p_lme_keep) else $error("paging dropped in long");

endmodule // opm_core

// File: tb/testbench.sv
// Self-checking bench for the operating-mode control block
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end

module testbench
    import opm_pkg::*;
;
    // ****************************************************************
    // Stimulus and wiring
    // ****************************************************************
    logic        ref_clk_i;
    logic        resetn_i;
    logic        clk_en_i;
    opm_wb_req_s req;
    logic        wb_ack_o;
    logic [31:0] wb_dat_o;
    opm_evt_s    evt;
    opm_mode_e   mode_o;
    opm_attr_s   attr_o;
    logic        mgmt_space_o;
    int          n_fail;
    int          n_compared;
    logic [31:0] d;

    localparam logic [31:0] PE  = 32'h0000_0001 << OPM_CTRL_PE;
    localparam logic [31:0] PG  = 32'h0000_0001 << OPM_CTRL_PG;
    localparam logic [31:0] LME = 32'h0000_0001 << OPM_CTRL_LME;
    localparam logic [31:0] CSL = 32'h0000_0001 << OPM_CTRL_CSL;
    localparam logic [31:0] CSD = 32'h0000_0001 << OPM_CTRL_CSD;

    opm_core u_opm_core (
        .ref_clk_i    (ref_clk_i),
        .resetn_i     (resetn_i),
        .clk_en_i     (clk_en_i),
        .wb_req_i     (req),
        .wb_ack_o     (wb_ack_o),
        .wb_dat_o     (wb_dat_o),
        .evt_i        (evt),
        .mode_o       (mode_o),
        .attr_o       (attr_o),
        .mgmt_space_o (mgmt_space_o)
    );

    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic summarize();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        resetn_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
    endtask

    // Classic single cycle: held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
        int n;
        @(posedge ref_clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: wd};
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        `CHK("ack", 1'b1, wb_ack_o)
        rd = wb_dat_o;
        req <= '0;
        repeat (2) @(posedge ref_clk_i);
    endtask

    task automatic pulse(input opm_evt_s e);
        @(posedge ref_clk_i);
        evt <= e;
        @(posedge ref_clk_i);
        evt <= '0;
        repeat (3) @(posedge ref_clk_i);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        do_reset();
        repeat (2) @(posedge ref_clk_i);
        `CHK("mode", OPM_REAL, mode_o)
        `CHK("attr", opm_attr_s'('0), attr_o)
        `CHK("pl max", OPM_PL_KERNEL, attr_o.pl_max)
        `CHK("space", OPM_AS_1M, attr_o.addr_space)
        wb(1'b0, 8'h10, 32'h0000_0000, d);
        `CHK("unmapped", 32'h0000_0000, d)
    endtask

    task automatic t_prot();
        do_reset();
        wb(1'b1, OPM_REG_CTRL, PG, d);
        wb(1'b0, OPM_REG_CTRL, 32'h0000_0000, d);
        `CHK("pg alone", 32'h0000_0000, d & PG)
        wb(1'b1, OPM_REG_CTRL, PE | CSD, d);
        `CHK("mode", OPM_PROT, mode_o)
        `CHK("space", OPM_AS_4G, attr_o.addr_space)
        `CHK("pl min", OPM_PL_KERNEL, attr_o.pl_min)
        `CHK("pl max", OPM_PL_USER, attr_o.pl_max)
        `CHK("oper", OPM_SZ32, attr_o.oper_size)
        wb(1'b0, OPM_REG_STATUS, 32'h0000_0000, d);
        `CHK("status mode", 3'(OPM_PROT), d[2:0])
        `CHK("status space", OPM_AS_4G, d[13:12])
    endtask

    task automatic t_long();
        opm_evt_s e;
        do_reset();
        wb(1'b1, OPM_REG_CTRL, LME, d);
        wb(1'b0, OPM_REG_CTRL, 32'h0000_0000, d);
        `CHK("lme early", 32'h0000_0000, d & LME)
        wb(1'b1, OPM_REG_CTRL, PE | PG, d);
        wb(1'b1, OPM_REG_CTRL, PE | PG | LME | CSL, d);
        `CHK("mode", OPM_LONG64, mode_o)
        `CHK("addr", OPM_SZ64, attr_o.addr_size)
        `CHK("oper", OPM_SZ32, attr_o.oper_size)
        `CHK("paging req", 1'b1, attr_o.paging_req)
        `CHK("flat", 1'b1, attr_o.flat_seg)
        `CHK("reg ext", 1'b1, attr_o.reg_ext)
        `CHK("wide ip", 1'b1, attr_o.wide_ip & attr_o.ip_rel)
        wb(1'b1, OPM_REG_CTRL, PE | PG | LME | CSD, d);
        `CHK("mode", OPM_COMPAT, mode_o)
        `CHK("space", OPM_AS_4G, attr_o.addr_space)
        `CHK("toggle", 1'b1, attr_o.prefix_toggle)
        `CHK("long xlat", 1'b1, attr_o.long_xlat)
        `CHK("flat", 1'b0, attr_o.flat_seg)
        `CHK("reg ext", 1'b0, attr_o.reg_ext)
        wb(1'b1, OPM_REG_CTRL, LME | CSD, d);
        wb(1'b0, OPM_REG_CTRL, 32'h0000_0000, d);
        `CHK("pe kept", PE | PG, d & (PE | PG))
        `CHK("active", 1'b1, d[5])
        `CHK("mode", OPM_COMPAT, mode_o)
        e = '0;
        e.task_switch = 1'b1;
        e.vm_value = 1'b1;
        pulse(e);
        wb(1'b0, OPM_REG_FLAGS, 32'h0000_0000, d);
        `CHK("vm", 1'b0, d[OPM_FLAGS_VM])
        `CHK("mode", OPM_COMPAT, mode_o)
    endtask

    task automatic t_vm();
        opm_evt_s e;
        do_reset();
        wb(1'b1, OPM_REG_CTRL, PE, d);
        e = '0;
        e.vm_value = 1'b1;
        e.flag_pop = 1'b1;
        pulse(e);
        `CHK("pop", OPM_PROT, mode_o)
        e = '0;
        e.vm_value = 1'b1;
        e.interrupt_return_instruction = 1'b1;
        e.cur_pl = OPM_PL_USER;
        pulse(e);
        `CHK("user interrupt_return_instruction", OPM_PROT, mode_o)
        e = '0;
        e.vm_value = 1'b1;
        e.task_switch = 1'b1;
        clk_en_i <= 1'b0;
        pulse(e);
        clk_en_i <= 1'b1;
        `CHK("frozen", OPM_PROT, mode_o)
        pulse(e);
        wb(1'b0, OPM_REG_FLAGS, 32'h0000_0000, d);
        `CHK("vm", 1'b1, d[OPM_FLAGS_VM])
        `CHK("mode", OPM_VREAL, mode_o)
        `CHK("pl", OPM_PL_USER, attr_o.pl_min)
        `CHK("space", OPM_AS_1M, attr_o.addr_space)
        `CHK("oper", OPM_SZ16, attr_o.oper_size)
        e = '0;
        e.interrupt_return_instruction = 1'b1;
        e.cur_pl = OPM_PL_KERNEL;
        pulse(e);
        `CHK("kernel interrupt_return_instruction", OPM_PROT, mode_o)
    endtask

    task automatic t_xlat(input logic [15:0] seg, input logic [15:0] off);
        logic [19:0] exp;
        exp = ({4'h0, seg} << OPM_SEG_SHIFT) + {4'h0, off};
        wb(1'b1, OPM_REG_XLAT, {seg, off}, d);
        wb(1'b0, OPM_REG_XLAT, 32'h0000_0000, d);
        `CHK("phys", exp, d[19:0])
    endtask

    task automatic t_mgmt();
        opm_evt_s e;
        e = '0;
        e.mgmt_int = 1'b1;
        e.mgmt_exit = 1'b1;
        pulse(e);
        `CHK("mode", OPM_MGMT, mode_o)
        `CHK("space", 1'b1, mgmt_space_o)
        e.mgmt_int = 1'b0;
        pulse(e);
        `CHK("space", 1'b0, mgmt_space_o)
    endtask

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial begin
        n_fail = 0;
        n_compared = 0;
        clk_en_i = 1'b1;
        req = '0;
        evt = '0;
        t_reset();
        t_prot();
        t_long();
        t_vm();
        do_reset();
        t_xlat(16'h1234, 16'h5678);
        t_xlat(16'hffff, 16'hffff);
        t_mgmt();
        summarize();
    end

    initial begin
        repeat (4000) @(posedge ref_clk_i);
        n_fail++;
        summarize();
    end

endmodule // testbench
